// *** hs_checker.sv ***
/*
  Checker for hs_homing, bound to the design's ports.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module hs_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic zero_pulse_in,
  input wire logic motion_en,
  input wire logic motion_dir_pos,
  input wire logic motion_fast,
  input wire logic origin_load,
  input wire logic homing_done,
  input wire logic homing_busy
);
  logic [7:0] meth_q;
  wire wr_ctrl = psel && penable && pwrite && paddr == 8'h00;
  wire start_w = wr_ctrl && pwdata[1:0] == 2'b11 && !homing_busy;
  // Mirror of the method register, so that starts can be judged per method.
  always @(posedge clk) begin
    if (sys_rst) meth_q <= 8'h22;
    else if (psel && penable && pwrite && paddr == 8'h04) meth_q <= pwdata[7:0];
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_load_end; origin_load |-> homing_done && !motion_en && !homing_busy; endproperty
  a_load_end: assert property (p_load_end)
    else $error("origin load without halt and done");
  property p_load_pulse; origin_load |=> !origin_load; endproperty
  a_load_pulse: assert property (p_load_pulse)
    else $error("origin load longer than one cycle");
  property p_done_rise; $rose(homing_done) |-> origin_load; endproperty
  a_done_rise: assert property (p_done_rise)
    else $error("done without origin load");
  property p_move_busy; motion_en |-> homing_busy; endproperty
  a_move_busy: assert property (p_move_busy)
    else $error("motion outside a run");
  property p_idle_stay; wr_ctrl && !pwdata[0] && !homing_busy |=> !homing_busy; endproperty
  a_idle_stay: assert property (p_idle_stay)
    else $error("run started while disabled");
  property p_m35; start_w && meth_q == 8'h23 |=> origin_load && !motion_en; endproperty
  a_m35: assert property (p_m35)
    else $error("method 35 did not set origin at once");
  property p_m34; start_w && meth_q == 8'h22 |=> motion_en && motion_dir_pos && !motion_fast;
  endproperty
  a_m34: assert property (p_m34)
    else $error("method 34 wrong start motion");
  property p_m33; start_w && meth_q == 8'h21 |=> motion_en && !motion_dir_pos && !motion_fast;
  endproperty
  a_m33: assert property (p_m33)
    else $error("method 33 wrong start motion");
  property p_zero_stop;
    (meth_q == 8'h21 || meth_q == 8'h22) && motion_en && $rose(zero_pulse_in)
      |-> ##[1:5] !motion_en;
  endproperty
  a_zero_stop: assert property (p_zero_stop)
    else $error("no stop at zero mark");
  c_load: cover property (origin_load);
  c_fast_neg: cover property (motion_en && motion_fast && !motion_dir_pos);
  c_endstop_rev: cover property (start_w && meth_q == 8'hFC);
endmodule // hs_checker
bind hs_homing hs_checker i_chk (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
  .zero_pulse_in, .motion_en, .motion_dir_pos, .motion_fast, .origin_load, .homing_done,
  .homing_busy);
`default_nettype wire

// *** hs_defs.vh ***
/*
  Constants of the homing sequencer: register offsets, field positions,
  reset values, phase event codes and the default end-stop blocking time.
  Assumes it is included by bare name in each design file that needs it.
*/
`ifndef HS_DEFS_VH
`define HS_DEFS_VH

// ----------------------------------------------------------------------
// Register offsets (byte addresses, one 32-bit word each)
// ----------------------------------------------------------------------
`define HS_OFF_CTRL 8'h00
`define HS_OFF_METHOD 8'h04
`define HS_OFF_STATUS 8'h08
`define HS_OFF_TORQUE_TH 8'h0C
`define HS_OFF_BLOCK_TIME 8'h10
`define HS_OFF_INVERT 8'h14
`define HS_OFF_FUNC 8'h18
`define HS_OFF_ORIGIN 8'h1C

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define HS_CTRL_ENABLE 0
`define HS_CTRL_START 1
`define HS_ST_DONE 0
`define HS_ST_BUSY 1
`define HS_ST_ERR 2
`define HS_INV_POS 0
`define HS_INV_NEG 1
`define HS_INV_REF 2
`define HS_INV_ZERO 3
`define HS_FUNC_REF 0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define HS_RST_METHOD 8'h22
`define HS_RST_TORQUE_TH 16'h0100
`define HS_RST_INVERT 4'h0
`define HS_RST_FUNC 1'h0
`define HS_RST_ORIGIN 32'h0000_0000

// ----------------------------------------------------------------------
// Default blocking time: figure in ms, clock in kHz, count in cycles
// ----------------------------------------------------------------------
`define HS_BLOCK_TIME_MS 10
`define HS_CLK_KHZ 10000
`define HS_BLOCK_CYC (`HS_BLOCK_TIME_MS * `HS_CLK_KHZ)

// ----------------------------------------------------------------------
// Phase stop events
// ----------------------------------------------------------------------
`define HS_EV_NONE 3'h0
`define HS_EV_REF_RISE 3'h1
`define HS_EV_REF_FALL 3'h2
`define HS_EV_ZERO 3'h3
`define HS_EV_NLIM_RISE 3'h4
`define HS_EV_NLIM_FALL 3'h5
`define HS_EV_ENDSTOP 3'h6

// ----------------------------------------------------------------------
// Start scenarios
// ----------------------------------------------------------------------
`define HS_SC_LOW 2'h0
`define HS_SC_HIGH 2'h1
`define HS_SC_LIMIT 2'h2

`endif

// *** hs_endstop.v ***
/*
  End-stop detector: flags a mechanical stop once the torque magnitude has
  stayed at or above the threshold for the blocking time in cycles.
  Assumes torque comes from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module hs_endstop (
  input wire clk,
  input wire sys_rst,
  input wire arm,
  input wire [15:0] torque,
  input wire [15:0] threshold,
  input wire [31:0] block_cyc,
  output reg hit
);
  reg [31:0] cnt_q;
  wire at_torque;

  // --------------------------------------------------------------------
  // Dwell counter
  // --------------------------------------------------------------------
  // Any dip below the threshold restarts the count, so a brief spike
  // never reads as a stop.
  assign at_torque = arm && (torque >= threshold);

  always @(posedge clk) begin
    if (sys_rst) begin
      cnt_q <= 32'h0000_0000;
      hit <= 1'b0;
    end else if (!at_torque) begin
      cnt_q <= 32'h0000_0000;
      hit <= 1'b0;
    end else begin
      if (cnt_q != 32'hFFFF_FFFF)
        cnt_q <= cnt_q + 32'h0000_0001;
      hit <= (cnt_q + 32'h0000_0001 >= block_cyc);
    end
  end
endmodule // hs_endstop
`default_nettype wire

// *** hs_homing.v ***
/*
  Homing sequencer with an APB register slave. Picks direction and speed
  per phase, stops phases on switch edges, zero pulse or end stop, and
  marks the origin when the method ends.
  Assumes switch and zero pulse pins are asynchronous and torque is on clk.
*/
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "hs_defs.vh"
module hs_homing #(
  parameter [31:0] BLOCK_CYC_RST = `HS_BLOCK_CYC
) (
  input wire clk,
  input wire sys_rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire positive_limit_in,
  input wire negative_limit_in,
  input wire home_ref_in,
  input wire zero_pulse_in,
  input wire [15:0] motor_torque,
  output reg motion_en,
  output reg motion_dir_pos,
  output reg motion_fast,
  output reg origin_load,
  output reg [31:0] origin_value,
  output reg homing_done,
  output reg homing_busy
);
  localparam [3:0] ST_IDLE = 4'h1, ST_RUN = 4'h2, ST_DONE = 4'h4, ST_ERR = 4'h8;

  // --------------------------------------------------------------------
  // Phase plan
  // --------------------------------------------------------------------
  // Returns {dir_pos, fast, stop event} for one phase; event NONE means
  // the method has ended. Methods 11-14 reuse 7-10 with direction turned.
  function [4:0] plan;
    input [7:0] m;
    input [1:0] sc;
    input [1:0] st;
    reg [7:0] b;
    reg mir;
    reg [4:0] r;
    begin
      mir = (m >= 8'd11) && (m <= 8'd14);
      b = mir ? m - 8'd4 : m;
      if ((b >= 8'd17) && (b <= 8'd30) && (b != 8'd21) && (b != 8'd22))
        b = 8'd17;
      r = {2'h0, `HS_EV_NONE};
      case (b)
        8'd7: case ({sc, st})
          4'h0: r = {2'h3, `HS_EV_REF_RISE};
          4'h1, 4'h4, 4'h9: r = {2'h0, `HS_EV_REF_FALL};
          4'h8: r = {2'h1, `HS_EV_REF_RISE};
          default: r = {2'h0, `HS_EV_NONE};
        endcase
        8'd8: case ({sc, st})
          4'h0: r = {2'h3, `HS_EV_REF_RISE};
          4'h1, 4'h5, 4'hA: r = {2'h2, `HS_EV_ZERO};
          4'h4, 4'h9: r = {2'h0, `HS_EV_REF_FALL};
          4'h8: r = {2'h1, `HS_EV_REF_RISE};
          default: r = {2'h0, `HS_EV_NONE};
        endcase
        8'd9: case ({sc, st})
          4'h0: r = {2'h3, `HS_EV_REF_RISE};
          4'h1: r = {2'h2, `HS_EV_REF_FALL};
          4'h2: r = {2'h0, `HS_EV_ZERO};
          4'h4: r = {2'h2, `HS_EV_REF_FALL};
          4'h5: r = {2'h0, `HS_EV_ZERO};
          4'h8: r = {2'h1, `HS_EV_REF_RISE};
          4'h9: r = {2'h0, `HS_EV_ZERO};
          default: r = {2'h0, `HS_EV_NONE};
        endcase
        8'd10: case ({sc, st})
          4'h0: r = {2'h3, `HS_EV_REF_RISE};
          4'h1: r = {2'h2, `HS_EV_REF_FALL};
          4'h2: r = {2'h2, `HS_EV_ZERO};
          4'h4: r = {2'h2, `HS_EV_REF_FALL};
          4'h5: r = {2'h2, `HS_EV_ZERO};
          4'h8: r = {2'h1, `HS_EV_REF_RISE};
          4'h9: r = {2'h2, `HS_EV_ZERO};
          default: r = {2'h0, `HS_EV_NONE};
        endcase
        8'd17: case ({sc, st})
          4'h0: r = {2'h1, `HS_EV_NLIM_RISE};
          4'h1: r = {2'h2, `HS_EV_NLIM_FALL};
          4'h4: r = {2'h2, `HS_EV_NLIM_FALL};
          default: r = {2'h0, `HS_EV_NONE};
        endcase
        8'd21: case ({sc, st})
          4'h4: r = {2'h2, `HS_EV_REF_FALL};
          4'h0: r = {2'h1, `HS_EV_REF_RISE};
          4'h1: r = {2'h2, `HS_EV_REF_FALL};
          default: r = {2'h0, `HS_EV_NONE};
        endcase
        8'd22: case ({sc, st})
          4'h4: r = {2'h3, `HS_EV_REF_FALL};
          4'h5: r = {2'h0, `HS_EV_REF_RISE};
          4'h0: r = {2'h0, `HS_EV_REF_RISE};
          default: r = {2'h0, `HS_EV_NONE};
        endcase
        8'd33: r = (st == 2'h0) ? {2'h0, `HS_EV_ZERO} : 5'h00;
        8'd34: r = (st == 2'h0) ? {2'h2, `HS_EV_ZERO} : 5'h00;
        8'hFC: case (st)
          2'h0: r = {2'h2, `HS_EV_ENDSTOP};
          2'h1: r = {2'h0, `HS_EV_ZERO};
          default: r = {2'h0, `HS_EV_NONE};
        endcase
        8'hFD: case (st)
          2'h0: r = {2'h0, `HS_EV_ENDSTOP};
          2'h1: r = {2'h2, `HS_EV_ZERO};
          default: r = {2'h0, `HS_EV_NONE};
        endcase
        8'hFE: r = (st == 2'h0) ? {2'h2, `HS_EV_ENDSTOP} : 5'h00;
        8'hFF: r = (st == 2'h0) ? {2'h0, `HS_EV_ENDSTOP} : 5'h00;
        default: r = {2'h0, `HS_EV_NONE};
      endcase
      if (mir && (r[2:0] != `HS_EV_NONE))
        r[4] = ~r[4];
      plan = r;
    end
  endfunction

  function uses_ref;
    input [7:0] m;
    uses_ref = ((m >= 8'd7) && (m <= 8'd14)) || (m == 8'd21) || (m == 8'd22);
  endfunction

  // --------------------------------------------------------------------
  // Registers and state
  // --------------------------------------------------------------------
  reg enable_q, err_q, ref_func_q, alt_q, ev_hit;
  reg [7:0] method_q;
  reg [15:0] torque_th_q;
  reg [31:0] block_cyc_q;
  reg [3:0] invert_q, state_q, sync_a_q, sync_b_q, prev_q;
  reg [1:0] scen_q, step_q;
  reg [2:0] ev_q;
  reg [4:0] next_plan;
  wire [3:0] lvl, lvl_prev;
  wire pos_lim, neg_lim, ref_lvl, ref_rise, ref_fall, nlim_rise, nlim_fall, zero_rise, es_hit;
  wire wr, rd, mapped, start_req, mir_now, alt_limit, class17, start_scen_hi, supported;
  wire [1:0] start_scen;
  wire [4:0] first_plan;

  // --------------------------------------------------------------------
  // Pin synchronisers and edges
  // --------------------------------------------------------------------
  // Inversion is applied after the second stage so the first stage feeds
  // nothing but the second one.
  always @(posedge clk) begin
    if (sys_rst) begin
      sync_a_q <= 4'h0;
      sync_b_q <= 4'h0;
      prev_q <= 4'h0;
    end else begin
      sync_a_q <= {zero_pulse_in, home_ref_in, negative_limit_in, positive_limit_in};
      sync_b_q <= sync_a_q;
      prev_q <= sync_b_q;
    end
  end

  assign lvl = sync_b_q ^ invert_q;
  assign lvl_prev = prev_q ^ invert_q;
  assign pos_lim = lvl[`HS_INV_POS];
  assign neg_lim = lvl[`HS_INV_NEG];
  assign ref_lvl = lvl[`HS_INV_REF];
  assign ref_rise = ref_lvl && !lvl_prev[`HS_INV_REF];
  assign ref_fall = !ref_lvl && lvl_prev[`HS_INV_REF];
  assign nlim_rise = neg_lim && !lvl_prev[`HS_INV_NEG];
  assign nlim_fall = !neg_lim && lvl_prev[`HS_INV_NEG];
  assign zero_rise = lvl[`HS_INV_ZERO] && !lvl_prev[`HS_INV_ZERO];

  // --------------------------------------------------------------------
  // APB slave
  // --------------------------------------------------------------------
  // Zero wait states; an unmapped address answers with pslverr.
  assign pready = 1'b1;
  assign wr = psel && penable && pwrite;
  assign rd = psel && !pwrite;
  assign mapped = (paddr[1:0] == 2'h0) && (paddr <= `HS_OFF_ORIGIN);
  assign pslverr = psel && penable && !mapped;
  assign start_req = wr && (paddr == `HS_OFF_CTRL) && pwdata[`HS_CTRL_START];

  always @(posedge clk) begin
    if (sys_rst) begin
      enable_q <= 1'b0;
      method_q <= `HS_RST_METHOD;
      torque_th_q <= `HS_RST_TORQUE_TH;
      block_cyc_q <= BLOCK_CYC_RST;
      invert_q <= `HS_RST_INVERT;
      ref_func_q <= `HS_RST_FUNC;
      origin_value <= `HS_RST_ORIGIN;
    end else if (wr) begin
      case (paddr)
        `HS_OFF_CTRL: enable_q <= pwdata[`HS_CTRL_ENABLE];
        `HS_OFF_METHOD: method_q <= pwdata[7:0];
        `HS_OFF_TORQUE_TH: torque_th_q <= pwdata[15:0];
        `HS_OFF_BLOCK_TIME: block_cyc_q <= pwdata;
        `HS_OFF_INVERT: invert_q <= pwdata[3:0];
        `HS_OFF_FUNC: ref_func_q <= pwdata[`HS_FUNC_REF];
        `HS_OFF_ORIGIN: origin_value <= pwdata;
        default: enable_q <= enable_q;
      endcase
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
    end else if (rd && !penable) begin
      case (paddr)
        `HS_OFF_CTRL: prdata <= {31'h0000_0000, enable_q};
        `HS_OFF_METHOD: prdata <= {24'h00_0000, method_q};
        `HS_OFF_STATUS: prdata <= {17'h0_0000, sync_b_q[2:0], 2'h0, step_q,
          state_q, 1'b0, err_q, homing_busy, homing_done};
        `HS_OFF_TORQUE_TH: prdata <= {16'h0000, torque_th_q};
        `HS_OFF_BLOCK_TIME: prdata <= block_cyc_q;
        `HS_OFF_INVERT: prdata <= {28'h000_0000, invert_q};
        `HS_OFF_FUNC: prdata <= {31'h0000_0000, ref_func_q};
        `HS_OFF_ORIGIN: prdata <= origin_value;
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Start decisions
  // --------------------------------------------------------------------
  assign class17 = (method_q >= 8'd17) && (method_q <= 8'd30) &&
    (method_q != 8'd21) && (method_q != 8'd22);
  assign start_scen_hi = class17 ? neg_lim : ref_lvl;
  assign start_scen = start_scen_hi ? `HS_SC_HIGH : `HS_SC_LOW;
  assign first_plan = plan(method_q, start_scen, 2'h0);
  assign supported = (method_q == 8'd35) || (first_plan[2:0] != `HS_EV_NONE);
  assign mir_now = (method_q >= 8'd11) && (method_q <= 8'd14);
  assign alt_limit = mir_now ? neg_lim : pos_lim;

  always @* begin
    case (ev_q)
      `HS_EV_REF_RISE: ev_hit = ref_rise;
      `HS_EV_REF_FALL: ev_hit = ref_fall;
      `HS_EV_ZERO: ev_hit = zero_rise;
      `HS_EV_NLIM_RISE: ev_hit = nlim_rise;
      `HS_EV_NLIM_FALL: ev_hit = nlim_fall;
      `HS_EV_ENDSTOP: ev_hit = es_hit;
      default: ev_hit = 1'b1;
    endcase
    next_plan = plan(method_q, scen_q, step_q + 2'h1);
  end

  hs_endstop u_endstop (
    .clk(clk), .sys_rst(sys_rst), .arm(state_q[1] && (ev_q == `HS_EV_ENDSTOP)),
    .torque(motor_torque), .threshold(torque_th_q), .block_cyc(block_cyc_q), .hit(es_hit)
  );

  // --------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------
  // Method register writes during a run are taken at once by the plan,
  // so software should not retune the method mid-run.
  always @(posedge clk) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      scen_q <= `HS_SC_LOW;
      step_q <= 2'h0;
      ev_q <= `HS_EV_NONE;
      alt_q <= 1'b0;
      err_q <= 1'b0;
      motion_en <= 1'b0;
      motion_dir_pos <= 1'b0;
      motion_fast <= 1'b0;
      origin_load <= 1'b0;
      homing_done <= 1'b0;
      homing_busy <= 1'b0;
    end else begin
      origin_load <= 1'b0;
      case (state_q)
        ST_IDLE, ST_DONE, ST_ERR: begin
          if (start_req && pwdata[`HS_CTRL_ENABLE]) begin
            homing_done <= 1'b0;
            if (!supported || (uses_ref(method_q) && !ref_func_q)) begin
              err_q <= 1'b1;
              state_q <= ST_ERR;
            end else if (method_q == 8'd35) begin
              origin_load <= 1'b1;
              homing_done <= 1'b1;
              err_q <= 1'b0;
              state_q <= ST_DONE;
            end else begin
              err_q <= 1'b0;
              scen_q <= start_scen;
              step_q <= 2'h0;
              ev_q <= first_plan[2:0];
              motion_dir_pos <= first_plan[4];
              motion_fast <= first_plan[3];
              motion_en <= 1'b1;
              homing_busy <= 1'b1;
              alt_q <= (method_q >= 8'd7) && (method_q <= 8'd14) && !start_scen_hi;
              state_q <= ST_RUN;
            end
          end
        end
        ST_RUN: begin
          if (!enable_q) begin
            motion_en <= 1'b0;
            homing_busy <= 1'b0;
            state_q <= ST_IDLE;
          end else if (alt_q && alt_limit) begin
            alt_q <= 1'b0;
            scen_q <= `HS_SC_LIMIT;
            step_q <= 2'h0;
            ev_q <= `HS_EV_REF_RISE;
            motion_dir_pos <= mir_now;
            motion_fast <= 1'b1;
          end else if (ev_hit) begin
            alt_q <= 1'b0;
            if (next_plan[2:0] == `HS_EV_NONE) begin
              motion_en <= 1'b0;
              origin_load <= 1'b1;
              homing_done <= 1'b1;
              homing_busy <= 1'b0;
              state_q <= ST_DONE;
            end else begin
              step_q <= step_q + 2'h1;
              ev_q <= next_plan[2:0];
              motion_dir_pos <= next_plan[4];
              motion_fast <= next_plan[3];
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
endmodule // hs_homing
`default_nettype wire

// *** hs_homing_tb.sv ***
/*
  Testbench for hs_homing: APB tasks and homing runs against the axis model.
  Assumes hs_checker is bound to the design.
*/
`timescale 1ns/1ps
`default_nettype none
`include "hs_defs.vh"
module hs_homing_tb;
  logic clk = 0;
  logic sys_rst = 1;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic load = 1;
  logic inv_ref = 0;
  logic signed [15:0] set_pos = 16'h0000;
  logic [15:0] seq_q = 16'h0000;
  logic [2:0] last_q = 3'h0;
  logic [31:0] rd_q;
  logic err_seen;
  int bad_count = 0;
  int n_checks = 0;
  wire [31:0] prdata;
  wire [31:0] origin_value;
  wire [15:0] motor_torque;
  wire pready, pslverr, positive_limit_in, negative_limit_in, home_ref_in, zero_pulse_in;
  wire motion_en, motion_dir_pos, motion_fast, origin_load, homing_done, homing_busy;
  always #50 clk = ~clk;
  hs_homing #(.BLOCK_CYC_RST(32'h0000_0014)) i_dut (.clk, .sys_rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .positive_limit_in,
    .negative_limit_in, .home_ref_in, .zero_pulse_in, .motor_torque, .motion_en,
    .motion_dir_pos, .motion_fast, .origin_load, .origin_value, .homing_done, .homing_busy);
  hs_plant i_plant (.clk, .load, .set_pos, .inv_ref, .motion_en, .motion_dir_pos,
    .motion_fast, .positive_limit_in, .negative_limit_in, .home_ref_in, .zero_pulse_in,
    .motor_torque);
  // Runs are judged by their list of motion commands; stop points shift with sync delay.
  always @(posedge clk) begin
    last_q <= {motion_en, motion_dir_pos, motion_fast};
    if (load) seq_q <= 16'h0000;
    else if (motion_en === 1'b1 && {motion_en, motion_dir_pos, motion_fast} !== last_q)
      seq_q <= {seq_q[11:0], 2'b01, motion_dir_pos, motion_fast};
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic timeout;
    bad_count++;
    $display("[FAIL] wait expected answer seen timeout");
    wrap_up();
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) timeout();
    rd_q = prdata;
    err_seen = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  task automatic run(input logic [7:0] m, input logic [15:0] p, input logic inv,
    input logic [15:0] exp);
    int n;
    set_pos <= p;
    load <= 1;
    inv_ref <= inv;
    @(posedge clk);
    load <= 0;
    apb(1, `HS_OFF_INVERT, {29'h0, inv, 2'h0});
    apb(1, `HS_OFF_METHOD, {24'h0, m});
    apb(1, `HS_OFF_CTRL, 32'h0000_0003);
    n = 0;
    while (homing_done !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 3000) timeout();
    chk("motion list", {16'h0, seq_q}, {16'h0, exp});
    chk("halted", {31'h0, motion_en}, 32'h0);
  endtask
  initial begin
    int m;
    repeat (2) @(posedge clk);
    sys_rst <= 0;
    load <= 0;
    @(posedge clk);
    apb(0, `HS_OFF_METHOD, 32'h0);
    chk("method reset", rd_q, 32'h0000_0022);
    apb(0, `HS_OFF_TORQUE_TH, 32'h0);
    chk("threshold reset", rd_q, 32'h0000_0100);
    apb(0, `HS_OFF_BLOCK_TIME, 32'h0);
    chk("block time reset", rd_q, 32'h0000_0014);
    apb(0, 8'h40, 32'h0);
    chk("unmapped data", rd_q, 32'h0);
    chk("unmapped error", {31'h0, err_seen}, 32'h1);
    apb(1, `HS_OFF_METHOD, 32'h0000_0015);
    apb(1, `HS_OFF_CTRL, 32'h0000_0003);
    apb(0, `HS_OFF_STATUS, 32'h0);
    chk("refused status", {24'h0, rd_q[7:0]}, 32'h0000_0084);
    chk("refused motion", {31'h0, motion_en}, 32'h0);
    apb(1, `HS_OFF_FUNC, 32'h0000_0001);
    apb(1, `HS_OFF_METHOD, 32'h0000_0022);
    apb(1, `HS_OFF_CTRL, 32'h0000_0003);
    apb(1, `HS_OFF_CTRL, 32'h0000_0000);
    @(posedge clk);
    chk("halt on disable", {31'h0, motion_en}, 32'h0);
    chk("no done on disable", {31'h0, homing_done}, 32'h0);
    apb(1, `HS_OFF_CTRL, 32'h0000_0002);
    chk("start while disabled", {31'h0, homing_busy}, 32'h0);
    apb(1, `HS_OFF_ORIGIN, 32'h0000_1234);
    chk("origin value", origin_value, 32'h0000_1234);
    run(8'h09, 16'h0000, 0, 16'h0764);
    run(8'h09, 16'h0104, 0, 16'h0064);
    run(8'h09, 16'h0190, 0, 16'h0754);
    run(8'h0A, 16'h0000, 0, 16'h0076);
    run(8'h0A, 16'h0104, 0, 16'h0006);
    run(8'h0A, 16'h0190, 0, 16'h0756);
    run(8'h0D, 16'h0000, 0, 16'h0576);
    run(8'h15, 16'h0104, 0, 16'h0006);
    run(8'h15, 16'h0190, 0, 16'h0056);
    run(8'h16, 16'h0104, 0, 16'h0074);
    run(8'h16, 16'h0190, 0, 16'h0004);
    run(8'h15, 16'h0104, 1, 16'h0006);
    run(8'h21, 16'h0000, 0, 16'h0004);
    run(8'h22, 16'h0000, 0, 16'h0006);
    run(8'h23, 16'h0000, 0, 16'h0000);
    run(8'hFE, 16'h0000, 0, 16'h0006);
    run(8'hFF, 16'h0000, 0, 16'h0004);
    run(8'hFC, 16'h0000, 0, 16'h0064);
    run(8'hFD, 16'h0000, 0, 16'h0046);
    for (m = 17; m <= 30; m++) begin
      if (m < 21 || m > 22) run(m[7:0], 16'h0000, 0, 16'h0056);
    end
    wrap_up();
  end
endmodule // hs_homing_tb
`default_nettype wire

// *** hs_plant.sv ***
/*
  Axis model: motor position, limit and reference switches, zero mark
  and hard walls. Assumes motion commands from the sequencer on clk.
*/
`timescale 1ns/1ps
`default_nettype none
module hs_plant (
  input wire logic clk,
  input wire logic load,
  input wire logic signed [15:0] set_pos,
  input wire logic inv_ref,
  input wire logic motion_en,
  input wire logic motion_dir_pos,
  input wire logic motion_fast,
  output logic positive_limit_in,
  output logic negative_limit_in,
  output logic home_ref_in,
  output logic zero_pulse_in,
  output logic [15:0] motor_torque
);
  int pos_q;
  int pos_d;
  // Fast moves four steps a clock, so the zero mark is four steps wide to be seen.
  always_comb begin
    pos_d = pos_q + (motion_dir_pos ? 1 : -1) * (motion_fast ? 4 : 1);
    if (pos_d > 800) pos_d = 800;
    if (pos_d < -800) pos_d = -800;
  end
  always @(posedge clk) begin
    if (load) pos_q <= set_pos;
    else if (motion_en) pos_q <= pos_d;
  end
  assign positive_limit_in = pos_q >= 600;
  assign negative_limit_in = pos_q <= -600;
  assign home_ref_in = (pos_q >= 200 && pos_q < 300) ^ inv_ref;
  assign zero_pulse_in = (pos_q + 1000) % 100 inside {[50:53]};
  // The wall pushes back only while the motor is commanded.
  assign motor_torque = (motion_en && (pos_q == 800 || pos_q == -800)) ? 16'h0200 : 16'h0010;
endmodule // hs_plant
`default_nettype wire
